//--- rtl/emb_pkg.sv
// Constants and state types for the external memory bus strobe block
package emb_pkg;

  // Bus widths
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;

  // Machine cycle: twelve oscillator periods, phases 0 to 11
  localparam logic [3:0] PH_LAST = 4'hb;
  localparam logic [3:0] PH_TAKE = 4'h5; // Phase where a data access is taken or ended
  localparam logic [3:0] ALE_A0 = 4'h0; // First latch strobe, two phases
  localparam logic [3:0] ALE_A1 = 4'h1;
  localparam logic [3:0] ALE_B0 = 4'h6; // Second latch strobe, two phases
  localparam logic [3:0] ALE_B1 = 4'h7;
  localparam logic [3:0] PS_A0 = 4'h3; // First code read strobe, two phases
  localparam logic [3:0] PS_A1 = 4'h4;
  localparam logic [3:0] PS_B0 = 4'h9; // Second code read strobe, two phases
  localparam logic [3:0] PS_B1 = 4'ha;
  localparam logic [3:0] ADR_A_LAST = 4'h2; // Low address held on the data bus through here
  localparam logic [3:0] ADR_B_LAST = 4'h8;
  localparam logic [3:0] STRB_FIRST = 4'h1; // Data strobe window in the access cycle
  localparam logic [3:0] STRB_LAST = 4'h4;

  // Reset pin qualification: two machine cycles of twelve clocks
  localparam int MC_CLKS = 12;
  localparam int RST_MCS = 2;
  localparam logic [4:0] RST_CLKS = 5'(RST_MCS * MC_CLKS);

  // Code addresses below this come from inside when external code select is high
  localparam logic [15:0] INT_CODE_TOP = 16'h1000;

  // Alternate function bit positions on the lower port
  localparam int ALT_RX = 0;
  localparam int ALT_TX = 1;
  localparam int ALT_IRQ0 = 2;
  localparam int ALT_IRQ1 = 3;
  localparam int ALT_CNT0 = 4;
  localparam int ALT_CNT1 = 5;
  localparam int ALT_WR = 6;
  localparam int ALT_RD = 7;

  // Synchroniser lanes
  localparam int SY_N = 7;
  localparam int SY_SEL = 5;
  localparam int SY_RST = 6;
  localparam logic SYNC_RST_VAL = 1'b0;

  // Data access sequence
  typedef enum logic [1:0] {
    EMB_IDLE   = 2'b00,
    EMB_ADDR   = 2'b01,
    EMB_STROBE = 2'b10
  } emb_dst_t;

  // Whole state of the strobe block
  typedef struct packed {
    logic [3:0]  phase;
    emb_dst_t    dst;
    logic        fetch_ext;
    logic        ale_off;
    logic        wr;
    logic        wide;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        ack;
    logic        ale;
    logic        code_rd_n;
    logic [7:0]  hi_out;
    logic [7:0]  hi_oe;
    logic [7:0]  hi_pu;
    logic [7:0]  alt_out;
    logic [7:0]  alt_oe;
    logic [7:0]  alt_pu;
    logic [7:0]  ad_out;
    logic        ad_oe;
    logic [4:0]  rst_cnt;
    logic        core_rst;
  } emb_state_t;

  localparam emb_state_t EMB_RST = '{
    phase: 4'h0, dst: EMB_IDLE, fetch_ext: 1'b1, ale_off: 1'b0, wr: 1'b0, wide: 1'b0,
    addr: 16'h0000, wdata: 8'h00, rdata: 8'h00, ack: 1'b0, ale: 1'b0, code_rd_n: 1'b1,
    hi_out: 8'hff, hi_oe: 8'h00, hi_pu: 8'hff, alt_out: 8'hff, alt_oe: 8'h00,
    alt_pu: 8'hff, ad_out: 8'h00, ad_oe: 1'b0, rst_cnt: 5'h00, core_rst: 1'b0};

  // Synchroniser state
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } emb_sync_t;

endpackage

//--- rtl/emb_strobes.sv
// External memory bus strobes, high address port and lower port alternate functions
//
// How it works
// RL1 - External code fetches and wide-pointer data accesses drive the high address byte.
// RL2 - Short-index data accesses leave the high port showing its latch.
// RL3 - Reset pin must stay high two machine cycles before core reset.
// RL4 - Address latch strobe pulses while the low address is on the bus; internal code fetches still pulse with the bus released.
// RL5 - Latch strobe pulses twice each machine cycle, one sixth of oscillator.
// RL6 - Each external data access drops exactly one latch strobe pulse.
// RL7 - Code read strobe twice per cycle; two dropped per data access.
// RL8 - Code read strobe stays inactive for internal code fetches.
// RL9 - External code select low forces all code fetches external.
// RL10 - Lower port bit six is the data write strobe.
// RL11 - Lower port bit seven is the data read strobe.
// RL12 - Lower port bits zero and one are serial receive and transmit.
// RL13 - Lower port bits two and three are external interrupt inputs.
// RL14 - Lower port bits four and five are timer count inputs.
// RL15 - A port bit not carrying an address is pulled up internally while it outputs one.
// RL16 - A strobe reaches its pin only while its latch bit is one.
// RL17 - Suppress bit stops regular latch strobes; data accesses keep theirs.
`timescale 1ns/100ps
module emb_strobes (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Core side: code address, port latches and controls
  input  wire logic [emb_pkg::ADDR_W-1:0]  pc,
  input  wire logic [emb_pkg::BYTE_W-1:0]  high_port_latch,
  input  wire logic [emb_pkg::BYTE_W-1:0]  alt_port_latch,
  input  wire logic                        tx_bit,
  input  wire logic                        ale_suppress,
  // Core side: external data move request and answer
  input  wire logic                        xfer_req,
  input  wire logic                        xfer_write,
  input  wire logic                        xfer_wide,
  input  wire logic [emb_pkg::ADDR_W-1:0]  xfer_addr,
  input  wire logic [emb_pkg::BYTE_W-1:0]  xfer_wdata,
  output logic                             xfer_ack,
  output logic [emb_pkg::BYTE_W-1:0]       xfer_rdata,
  // Core side: alternate inputs, fetch source and core reset, filtered
  output logic                             rx_bit,
  output logic                             ext_irq_zero,
  output logic                             ext_irq_one,
  output logic                             count_in_zero,
  output logic                             count_in_one,
  output logic                             fetch_ext,
  output logic                             core_reset,
  // Pins: strobes and control inputs
  output logic                             ale,
  output logic                             code_read_strobe_n,
  input  wire logic                        ext_code_select,
  input  wire logic                        rst_pin,
  // Pins: multiplexed low address and data bus
  input  wire logic [emb_pkg::BYTE_W-1:0]  ad_in,
  output logic [emb_pkg::BYTE_W-1:0]       ad_out,
  output logic                             ad_oe,
  // Pins: high address port
  output logic [emb_pkg::BYTE_W-1:0]       hi_port_out,
  output logic [emb_pkg::BYTE_W-1:0]       hi_port_oe,
  output logic [emb_pkg::BYTE_W-1:0]       hi_port_pullup,
  // Pins: alternate function port
  input  wire logic [emb_pkg::BYTE_W-1:0]  alt_port_in,
  output logic [emb_pkg::BYTE_W-1:0]       alt_port_out,
  output logic [emb_pkg::BYTE_W-1:0]       alt_port_oe,
  output logic [emb_pkg::BYTE_W-1:0]       alt_port_pullup
);
  import emb_pkg::*;

  emb_state_t      s_r;
  emb_state_t      s_nxt;
  logic [SY_N-1:0] sy_in;
  logic [SY_N-1:0] sy_q;

  // Pin inputs through the synchroniser lanes
  assign sy_in = {rst_pin, ext_code_select, alt_port_in[ALT_CNT1], alt_port_in[ALT_CNT0],
                  alt_port_in[ALT_IRQ1], alt_port_in[ALT_IRQ0], alt_port_in[ALT_RX]};

  genvar gi;
  generate
    for (gi = 0; gi < SY_N; gi++) begin : g_sync
      emb_sync3 emb_sync3_i (
        .clk   (clk),
        .reset (reset),
        .d     (sy_in[gi]),
        .q     (sy_q[gi])
      );
    end
  endgenerate

  // Alternate inputs handed to the core
  assign rx_bit        = sy_q[0]; // RL12
  assign ext_irq_zero  = sy_q[1]; // RL13
  assign ext_irq_one   = sy_q[2]; // RL13
  assign count_in_zero = sy_q[3]; // RL14
  assign count_in_one  = sy_q[4]; // RL14

  // Next state: phase counter, data access sequence and pin values
  always_comb begin
    logic       strb;
    logic       ale_win;
    logic       ps_win;
    logic       adr_win;
    logic [7:0] v;
    s_nxt = s_r;
    strb = 1'b0;
    ale_win = 1'b0;
    ps_win = 1'b0;
    adr_win = 1'b0;
    v = 8'h00;
    s_nxt.ack = 1'b0;
    s_nxt.phase = (s_r.phase == PH_LAST) ? 4'h0 : s_r.phase + 4'h1;
    // Fetch source and suppress bit are fixed for a whole machine cycle
    if (s_nxt.phase == 4'h0) begin
      s_nxt.fetch_ext = !sy_q[SY_SEL] || (pc >= INT_CODE_TOP); // RL9
      s_nxt.ale_off = ale_suppress;
    end
    // Data access: taken at phase five, address half cycle, strobe half cycle
    case (s_r.dst)
      EMB_IDLE: begin
        if (s_r.phase == PH_TAKE && xfer_req) begin
          s_nxt.dst = EMB_ADDR;
          s_nxt.wr = xfer_write;
          s_nxt.wide = xfer_wide;
          s_nxt.addr = xfer_addr;
          s_nxt.wdata = xfer_wdata;
        end
      end
      EMB_ADDR: begin
        if (s_r.phase == PH_LAST) begin
          s_nxt.dst = EMB_STROBE;
        end
      end
      EMB_STROBE: begin
        if (s_r.phase == STRB_LAST && !s_r.wr) begin
          s_nxt.rdata = ad_in; // Sampled on the last cycle of the read strobe
        end
        if (s_r.phase == PH_TAKE) begin
          s_nxt.dst = EMB_IDLE;
          s_nxt.ack = 1'b1;
        end
      end
      default: begin
        s_nxt.dst = EMB_IDLE;
      end
    endcase
    // Windows within the machine cycle
    ale_win = (s_nxt.phase == ALE_A0) || (s_nxt.phase == ALE_A1) ||
              (s_nxt.phase == ALE_B0) || (s_nxt.phase == ALE_B1);
    ps_win  = (s_nxt.phase == PS_A0) || (s_nxt.phase == PS_A1) ||
              (s_nxt.phase == PS_B0) || (s_nxt.phase == PS_B1);
    adr_win = (s_nxt.phase <= ADR_A_LAST) ||
              ((s_nxt.phase >= ALE_B0) && (s_nxt.phase <= ADR_B_LAST));
    strb = (s_nxt.dst == EMB_STROBE) && (s_nxt.phase >= STRB_FIRST) &&
           (s_nxt.phase <= STRB_LAST);
    // Latch strobe: regular train unless suppressed, data address pulse always
    s_nxt.ale = (ale_win && !s_nxt.ale_off && s_nxt.dst == EMB_IDLE) || // RL5 RL17
                (ale_win && s_nxt.dst == EMB_ADDR); // RL4 RL6
    // Code read strobe only for external fetches, none in a data access
    s_nxt.code_rd_n = !(ps_win && s_nxt.fetch_ext && s_nxt.dst == EMB_IDLE); // RL7 RL8
    // Low byte on the data bus: address around each pulse except during internal fetches, write data in the strobe
    s_nxt.ad_oe = 1'b0;
    s_nxt.ad_out = 8'h00;
    if (s_nxt.dst == EMB_ADDR && adr_win) begin
      s_nxt.ad_oe = 1'b1; // RL4
      s_nxt.ad_out = s_nxt.addr[7:0];
    end else if (s_nxt.dst == EMB_STROBE && s_nxt.wr) begin
      s_nxt.ad_oe = 1'b1;
      s_nxt.ad_out = s_nxt.wdata;
    end else if (s_nxt.dst == EMB_IDLE && s_nxt.fetch_ext && adr_win) begin
      s_nxt.ad_oe = 1'b1; // RL4
      s_nxt.ad_out = pc[7:0];
    end
    // High port: address driven strongly, else the latch with weak pull-ups
    if (s_nxt.dst != EMB_IDLE && s_nxt.wide) begin
      s_nxt.hi_out = s_nxt.addr[15:8]; // RL1
      s_nxt.hi_oe = 8'hff;
      s_nxt.hi_pu = 8'h00;
    end else if (s_nxt.dst == EMB_IDLE && s_nxt.fetch_ext) begin
      s_nxt.hi_out = pc[15:8]; // RL1
      s_nxt.hi_oe = 8'hff;
      s_nxt.hi_pu = 8'h00;
    end else begin
      s_nxt.hi_out = high_port_latch; // RL2
      s_nxt.hi_oe = ~high_port_latch; // RL15
      s_nxt.hi_pu = high_port_latch; // RL15
    end
    // Lower port: each alternate output is gated by its own latch bit
    v = alt_port_latch;
    v[ALT_TX] = alt_port_latch[ALT_TX] & tx_bit; // RL12
    v[ALT_WR] = alt_port_latch[ALT_WR] & !(strb && s_nxt.wr); // RL10 RL16
    v[ALT_RD] = alt_port_latch[ALT_RD] & !(strb && !s_nxt.wr); // RL11 RL16
    s_nxt.alt_out = v;
    s_nxt.alt_oe = ~v; // RL15
    s_nxt.alt_pu = v; // RL15
    // Reset pin qualification over two machine cycles
    if (!sy_q[SY_RST]) begin
      s_nxt.rst_cnt = 5'h00;
    end else if (s_r.rst_cnt != RST_CLKS) begin
      s_nxt.rst_cnt = s_r.rst_cnt + 5'h01; // RL3
    end
    s_nxt.core_rst = (s_nxt.rst_cnt == RST_CLKS); // RL3
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= EMB_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign xfer_ack           = s_r.ack;
  assign xfer_rdata         = s_r.rdata;
  assign fetch_ext          = s_r.fetch_ext;
  assign core_reset         = s_r.core_rst;
  assign ale                = s_r.ale;
  assign code_read_strobe_n = s_r.code_rd_n;
  assign ad_out             = s_r.ad_out;
  assign ad_oe              = s_r.ad_oe;
  assign hi_port_out        = s_r.hi_out;
  assign hi_port_oe         = s_r.hi_oe;
  assign hi_port_pullup     = s_r.hi_pu;
  assign alt_port_out       = s_r.alt_out;
  assign alt_port_oe        = s_r.alt_oe;
  assign alt_port_pullup    = s_r.alt_pu;

  // Checks on the strobe timing
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_wr_low;
    !alt_port_out[ALT_WR] [*4];
  endsequence

  sequence seq_rd_low;
    !alt_port_out[ALT_RD] [*4];
  endsequence

  a_ale_period: assert property ( // RL5
    $rose(ale) && s_r.phase == ALE_A0 && !s_r.ale_off |-> ##6 (ale || s_r.ale_off))
    else $error("Latch strobe not repeated after six clocks");
  a_ale_skip: assert property ( // RL6
    s_r.dst == EMB_STROBE && (s_r.phase == ALE_A0 || s_r.phase == ALE_A1) |-> !ale)
    else $error("Latch strobe not dropped in data access");
  a_ale_addr: assert property ( // RL4
    s_r.dst == EMB_ADDR && s_r.phase == ALE_B0 |-> ale && ad_oe ##1 ale ##1 !ale && ad_oe)
    else $error("Data address latch pulse wrong");
  a_code_twice: assert property ( // RL7
    s_r.dst == EMB_IDLE && s_r.fetch_ext && s_r.phase == PS_A0 |->
      !code_read_strobe_n [*2] ##1 code_read_strobe_n)
    else $error("Code read strobe pulse wrong");
  a_code_skip: assert property ( // RL7
    s_r.dst != EMB_IDLE |-> code_read_strobe_n)
    else $error("Code read strobe during data access");
  a_code_internal: assert property ( // RL8
    !s_r.fetch_ext |-> code_read_strobe_n)
    else $error("Code read strobe on internal fetch");
  a_hi_wide: assert property ( // RL1
    s_r.dst != EMB_IDLE && s_r.wide |-> hi_port_out == s_r.addr[15:8] && hi_port_oe == 8'hff)
    else $error("High address byte not driven");
  a_hi_latch: assert property ( // RL2
    s_r.dst != EMB_IDLE && !s_r.wide && $stable(high_port_latch) |->
      hi_port_out == $past(high_port_latch))
    else $error("High port not showing its latch");
  a_wr_strobe: assert property ( // RL10
    s_r.dst == EMB_ADDR && s_r.phase == PH_LAST && s_r.wr && alt_port_latch[ALT_WR] &&
      $stable(alt_port_latch) |-> ##1 alt_port_out[ALT_WR] ##1 seq_wr_low ##1 alt_port_out[ALT_WR])
    else $error("Write strobe shape wrong");
  a_rd_strobe: assert property ( // RL11
    s_r.dst == EMB_ADDR && s_r.phase == PH_LAST && !s_r.wr && alt_port_latch[ALT_RD] &&
      $stable(alt_port_latch) |-> ##1 alt_port_out[ALT_RD] ##1 seq_rd_low ##1 alt_port_out[ALT_RD])
    else $error("Read strobe shape wrong");
  a_strobe_gate: assert property ( // RL16
    !$past(alt_port_latch[ALT_WR]) |-> !alt_port_out[ALT_WR] && alt_port_oe[ALT_WR])
    else $error("Write pin not held low by its latch");
  a_reset_qual: assert property ( // RL3
    $rose(core_reset) |-> s_r.rst_cnt == RST_CLKS && $past(s_r.rst_cnt) == RST_CLKS - 5'h01)
    else $error("Core reset without two machine cycles of pin");
endmodule

//--- rtl/emb_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module emb_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin in, filtered level out
  input  wire logic d,
  output logic      q
);
  import emb_pkg::*;

  emb_sync_t s_r;
  emb_sync_t s_nxt;

  // Shift the pin in; the output follows once stages two and three agree
  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.q  = (s_r.s2 == s_r.s3) ? s_r.s3 : s_r.q;
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '{s1: SYNC_RST_VAL, s2: SYNC_RST_VAL, s3: SYNC_RST_VAL, q: SYNC_RST_VAL};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule

//--- test/emb_ext_mem.sv
// External program and data memory with its address latch
`timescale 1ns/100ps
module emb_ext_mem #(
  parameter int RD_WAIT = 0
) (
  // Clock
  input  wire logic       clk,
  // Strobes and buses from the block
  input  wire logic       ale,
  input  wire logic       code_read_strobe_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic [7:0] ad_out,
  input  wire logic       ad_oe,
  input  wire logic [7:0] hi_port_out,
  // Data bus back to the block
  output logic [7:0]      ad_in
);
  logic [7:0]  mem [0:65535];
  logic [15:0] acc_addr = 16'h0000;
  logic [7:0]  ad_last = 8'h00;
  int          rd_age = 0;

  // Latch low byte as the strobe falls, high byte from the high port
  always @(negedge ale) begin
    acc_addr = {hi_port_out, ad_out};
  end

  // Write and track read strobe age on the falling clock edge, where strobes are settled
  always @(negedge clk) begin
    if (!wr_n && ad_oe) begin
      mem[acc_addr] <= ad_out;
    end
    rd_age <= rd_n ? 0 : rd_age + 1;
    ad_last <= ad_in;
  end

  // Slow read data; a released bus shows a changing pattern
  always_comb begin
    if (!rd_n && rd_age >= RD_WAIT) begin
      ad_in = mem[acc_addr];
    end else if (!code_read_strobe_n) begin
      ad_in = acc_addr[7:0] ^ 8'h5a;
    end else begin
      ad_in = ~ad_last;
    end
  end
endmodule

//--- test/tb_emb_strobes.sv
// Self-checking testbench for the external memory bus strobe block
`timescale 1ns/100ps
module tb_emb_strobes;
  import emb_pkg::*;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] pc = 16'h2000;
  logic [7:0]  high_port_latch = 8'hff;
  logic [7:0]  alt_port_latch = 8'hff;
  logic        tx_bit = 1'b1;
  logic        ale_suppress = 1'b0;
  logic        xfer_req = 1'b0;
  logic        xfer_write = 1'b0;
  logic        xfer_wide = 1'b0;
  logic [15:0] xfer_addr = 16'h0000;
  logic [7:0]  xfer_wdata = 8'h00;
  logic        ext_code_select = 1'b0;
  logic        rst_pin = 1'b0;
  logic [7:0]  alt_port_in = 8'hff;
  logic [7:0]  ad_in, ad_out, xfer_rdata, hi_out, hi_oe, hi_pu, alt_out, alt_oe, alt_pu, got_rd;
  logic        xfer_ack, rx_bit, irq0, irq1, cnt0, cnt1, fetch_ext, core_reset, ale, ps_n, ad_oe;
  logic        ale_q = 1'b0;
  logic        ps_q = 1'b1;
  logic        wr_q = 1'b1;
  logic        rd_q = 1'b1;
  int          errors = 0;
  int          num_checks = 0;
  int          cyc, ale_cnt, ps_cnt, wr_cnt, rd_cnt;

  always #50 clk = ~clk;

  emb_strobes emb_strobes_i (
    .clk(clk), .reset(reset), .pc(pc), .high_port_latch(high_port_latch),
    .alt_port_latch(alt_port_latch), .tx_bit(tx_bit), .ale_suppress(ale_suppress),
    .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_wide(xfer_wide),
    .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_ack(xfer_ack),
    .xfer_rdata(xfer_rdata), .rx_bit(rx_bit), .ext_irq_zero(irq0), .ext_irq_one(irq1),
    .count_in_zero(cnt0), .count_in_one(cnt1), .fetch_ext(fetch_ext),
    .core_reset(core_reset), .ale(ale), .code_read_strobe_n(ps_n),
    .ext_code_select(ext_code_select), .rst_pin(rst_pin), .ad_in(ad_in), .ad_out(ad_out),
    .ad_oe(ad_oe), .hi_port_out(hi_out), .hi_port_oe(hi_oe), .hi_port_pullup(hi_pu),
    .alt_port_in(alt_port_in), .alt_port_out(alt_out), .alt_port_oe(alt_oe),
    .alt_port_pullup(alt_pu));

  emb_ext_mem #(.RD_WAIT(2)) emb_ext_mem_i (
    .clk(clk), .ale(ale), .code_read_strobe_n(ps_n), .wr_n(alt_out[6]), .rd_n(alt_out[7]),
    .ad_out(ad_out), .ad_oe(ad_oe), .hi_port_out(hi_out), .ad_in(ad_in));

  // Count strobe edges on the falling clock edge, where outputs are settled
  always @(negedge clk) begin
    cyc++;
    if (ale && !ale_q) ale_cnt++;
    if (!ps_n && ps_q) ps_cnt++;
    if (!alt_out[6] && wr_q) wr_cnt++;
    if (!alt_out[7] && rd_q) rd_cnt++;
    ale_q = ale;
    ps_q = ps_n;
    wr_q = alt_out[6];
    rd_q = alt_out[7];
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One data move: hold the request until acknowledged, drop it after
  task automatic xfer(input logic w, input logic wide, input logic [15:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    xfer_req <= 1'b1;
    xfer_write <= w;
    xfer_wide <= wide;
    xfer_addr <= a;
    xfer_wdata <= d;
    do begin
      @(negedge clk);
      n++;
    end while (xfer_ack !== 1'b1 && n < 40);
    chk(16'(xfer_ack), 16'h0001);
    got_rd = xfer_rdata;
    @(posedge clk);
    xfer_req <= 1'b0;
  endtask

  // Align on an access, then count strobes over four machine cycles holding one access
  task automatic window(input logic w, input logic wide, input logic [15:0] a,
                        input logic [7:0] d, input int ea, input int ep, input int es);
    int c0, a0, p0, s0;
    xfer(1'b0, 1'b1, 16'h0000, 8'h00);
    c0 = cyc;
    a0 = ale_cnt;
    p0 = ps_cnt;
    s0 = w ? wr_cnt : rd_cnt;
    xfer(w, wide, a, d);
    while (cyc - c0 < 48) @(posedge clk);
    chk(16'(ale_cnt - a0), 16'(ea));
    chk(16'(ps_cnt - p0), 16'(ep));
    chk(16'((w ? wr_cnt : rd_cnt) - s0), 16'(es));
  endtask

  task automatic t_idle;
    int a0, p0;
    repeat (30) @(posedge clk);
    a0 = ale_cnt;
    p0 = ps_cnt;
    repeat (48) @(posedge clk);
    chk(16'(ale_cnt - a0), 16'h0008);
    chk(16'(ps_cnt - p0), 16'h0008);
    chk(16'(fetch_ext), 16'h0001);
    $display("test idle done");
  endtask

  task automatic t_alt;
    logic [7:0] p;
    for (int i = 0; i < 2; i++) begin
      p = (i == 0) ? 8'h15 : 8'h2a;
      @(posedge clk);
      alt_port_in <= p;
      tx_bit <= p[0];
      repeat (6) @(negedge clk);
      chk(16'({cnt1, cnt0}), 16'({p[5], p[4]}));
      chk(16'({irq1, irq0}), 16'({p[3], p[2]}));
      chk(16'({alt_out[1], rx_bit}), 16'({p[0], p[0]}));
      chk(16'(alt_pu), 16'({6'h3f, p[0], 1'b1}));
    end
    @(posedge clk);
    alt_port_in <= 8'hff;
    tx_bit <= 1'b1;
    $display("test alt done");
  endtask

  task automatic t_rstpin;
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (10) @(posedge clk);
    rst_pin <= 1'b0;
    repeat (30) begin
      @(negedge clk);
      chk(16'(core_reset), 16'h0000);
    end
    @(posedge clk);
    rst_pin <= 1'b1;
    repeat (32) @(negedge clk);
    chk(16'(core_reset), 16'h0001);
    @(posedge clk);
    rst_pin <= 1'b0;
    repeat (8) @(negedge clk);
    chk(16'(core_reset), 16'h0000);
    $display("test rstpin done");
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk(16'({ale, ps_n}), 16'h0001);
    chk(16'({alt_pu, hi_pu}), 16'hffff);
    $display("test reset done");
    t_idle();
    window(1'b1, 1'b1, 16'h4a5c, 8'ha3, 7, 6, 1);
    chk(16'(emb_ext_mem_i.mem[16'h4a5c]), 16'h00a3);
    $display("test write done");
    high_port_latch <= 8'h4a;
    window(1'b0, 1'b0, 16'hff5c, 8'h00, 7, 6, 1);
    chk(16'(got_rd), 16'h00a3);
    $display("test read done");
    alt_port_latch <= 8'h3f;
    window(1'b0, 1'b1, 16'h4a5c, 8'h00, 7, 6, 0);
    chk(16'(alt_out[7]), 16'h0000);
    chk(16'({alt_out[6], alt_oe[6]}), 16'h0001);
    alt_port_latch <= 8'hff;
    $display("test gate done");
    ale_suppress <= 1'b1;
    window(1'b1, 1'b1, 16'h1234, 8'h5a, 1, 6, 1);
    ale_suppress <= 1'b0;
    $display("test suppress done");
    ext_code_select <= 1'b1;
    pc <= 16'h0100;
    repeat (24) @(posedge clk);
    chk(16'(fetch_ext), 16'h0000);
    chk(16'({hi_oe, hi_pu}), 16'hb54a);
    chk(16'(hi_out), 16'h004a);
    window(1'b0, 1'b1, 16'h4a5c, 8'h00, 7, 0, 1);
    $display("test internal done");
    t_alt();
    t_rstpin();
    wrap_up();
  end

  // Watchdog for a hung handshake
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule
